// ==== dsync_pkg.sv ====
package dsync_pkg;

  // Clock and time base
  localparam int CLK_MHZ = 100;
  localparam int CLK_HZ = 100_000_000;

  // Pixel clock synthesis: step size in Hz and accumulator modulus
  localparam int PIX_STEP_HZ = 73250;
  localparam int PIX_MOD = CLK_HZ / PIX_STEP_HZ;
  localparam int PIX_ACC_W = 11;
  localparam int PIX_W = 10;

  // Horizontal period unit, clamp unit, generated pulse widths
  localparam int HP_STEP_NS = 30;
  localparam int HP_STEP_CYC = (HP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CLAMP_STEP_NS = 480;
  localparam int CLAMP_STEP_CYC = (CLAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int HS_WIDTH_NS = 4700;
  localparam int HS_WIDTH_CYC = (HS_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int VS_LINES = 3;
  // Sandcastle pulse longer than this carries the vertical component
  localparam int SC_VS_NS = 8000;
  localparam int SC_VS_CYC = (SC_VS_NS * CLK_MHZ + 999) / 1000;

  // Field widths
  localparam int HCYC_W = 14;
  localparam int LINE_W = 11;
  localparam int PIXC_W = 12;
  localparam int HP_W = 12;
  localparam int CLMP_W = 8;

  // Register offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h01;
  localparam logic [4:0] OFS_MASK = 5'h02;
  localparam logic [4:0] OFS_LPF_LO = 5'h03;
  localparam logic [4:0] OFS_LPF_HI = 5'h04;
  localparam logic [4:0] OFS_HP_LO = 5'h05;
  localparam logic [4:0] OFS_HP_HI = 5'h06;
  localparam logic [4:0] OFS_VDLY_LO = 5'h07;
  localparam logic [4:0] OFS_VDLY_HI = 5'h08;
  localparam logic [4:0] OFS_HDLY_LO = 5'h09;
  localparam logic [4:0] OFS_HDLY_HI = 5'h0a;
  localparam logic [4:0] OFS_HCB = 5'h0b;
  localparam logic [4:0] OFS_HCE = 5'h0c;
  localparam logic [4:0] OFS_VCB_LO = 5'h0d;
  localparam logic [4:0] OFS_VCB_HI = 5'h0e;
  localparam logic [4:0] OFS_VCE_LO = 5'h0f;
  localparam logic [4:0] OFS_VCE_HI = 5'h10;
  localparam logic [4:0] OFS_PIX_LO = 5'h11;
  localparam logic [4:0] OFS_PIX_HI = 5'h12;

  // Control and status bit positions
  localparam int CTL_MASTER = 0;
  localparam int CTL_SANDCASTLE = 1;
  localparam int ST_HSYNC = 0;
  localparam int ST_VSYNC = 1;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [LINE_W-1:0] LPF_RST = 11'h271;
  localparam logic [HP_W-1:0] HP_RST = 12'h855;
  localparam logic [LINE_W-1:0] VDLY_RST = 11'h020;
  localparam logic [PIXC_W-1:0] HDLY_RST = 12'h048;
  localparam logic [CLMP_W-1:0] HCB_RST = 8'h00;
  localparam logic [CLMP_W-1:0] HCE_RST = 8'h0a;
  localparam logic [LINE_W-1:0] VCB_RST = 11'h000;
  localparam logic [LINE_W-1:0] VCE_RST = 11'h004;
  localparam logic [PIX_W-1:0] PIX_RST = 10'h0a4;

  // One display pixel: colour, blanking and contrast reduction
  typedef struct packed {
    logic [2:0] rgb;
    logic blank;
    logic contrast;
  } dsync_pix_s;

endpackage : dsync_pkg

// ==== dsync_pixclk.sv ====
`timescale 1ns/1ps
// Pixel rate enable from a modulo phase accumulator; free running, never
// realigned to the line, so its phase against sync is arbitrary.
module dsync_pixclk #(
  parameter int ACC_W = dsync_pkg::PIX_ACC_W,
  parameter int STEP_W = dsync_pkg::PIX_W,
  parameter logic [ACC_W-1:0] MODULUS = ACC_W'(dsync_pkg::PIX_MOD)
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [STEP_W-1:0] step_in,
  output logic pix_en_out
);

  logic [ACC_W:0] acc_r;
  logic [ACC_W:0] sum;

  assign sum = acc_r + {{(ACC_W+1-STEP_W){1'b0}}, step_in};

  // Overflow past the modulus yields one pixel enable
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= '0;
      pix_en_out <= 1'b0;
    end else if (sum >= {1'b0, MODULUS}) begin
      acc_r <= sum - {1'b0, MODULUS};
      pix_en_out <= 1'b1;
    end else begin
      acc_r <= sum;
      pix_en_out <= 1'b0;
    end
  end

endmodule : dsync_pixclk

// ==== dsync_timing.sv ====
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - Own timing, apart from acquisition; software picks master or slave.
// - Slave takes separate H and V pins or one sandcastle pulse.
// - Slave accepts any sync rate; no fixed ratio to pixel clock.
// - Master drives H and V with programmable period and line count.
// - Clamp area forces black; blank and contrast use subtable zero values.
// - Clamp area set in lines vertically, 480 ns units horizontally.
// - Border surrounds character area; colour from one lookup vector.
// - Character area offset by vertical and horizontal sync delays.
// - Character area size comes from the display generator format.
// - Pixel clock 10 to 32 MHz in 73.25 kHz steps, default 12.01.
// - Lines per field 1 to 1024; line period in 30 ns steps.
// - Vertical clamp begin and end in lines, defaults 0 and 4.
// - Horizontal clamp begin and end in 480 ns steps, defaults 0, 4.8 us.
// - Interrupts on rising edge of undelayed H and V at pins.
// - Hardware sets sync flags; only software clears them.
// - Clamp overrides background and character area.
module dsync_timing (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic hsync_in,
  input wire logic vsync_in,
  output logic hsync_out,
  output logic hsync_oe_out,
  output logic vsync_out,
  output logic vsync_oe_out,
  input wire logic [dsync_pkg::PIXC_W-1:0] fmt_width_in,
  input wire logic [dsync_pkg::LINE_W-1:0] fmt_height_in,
  input wire dsync_pkg::dsync_pix_s char_pix_in,
  input wire dsync_pkg::dsync_pix_s border_pix_in,
  input wire dsync_pkg::dsync_pix_s sub0_pix_in,
  output dsync_pkg::dsync_pix_s pix_out,
  output logic char_area_out,
  output logic clamp_out,
  output logic pix_en_out,
  output logic irq_out
);

  localparam int HCYC_W = dsync_pkg::HCYC_W;
  localparam int LINE_W = dsync_pkg::LINE_W;
  localparam int PIXC_W = dsync_pkg::PIXC_W;
  localparam int HP_W = dsync_pkg::HP_W;
  localparam int CLMP_W = dsync_pkg::CLMP_W;

  typedef enum logic [1:0] {
    DSYNC_SC_IDLE = 2'b00,
    DSYNC_SC_HIGH = 2'b01,
    DSYNC_SC_VERT = 2'b11
  } dsync_sc_e;

  // Registers
  logic [1:0] sync_control_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [LINE_W-1:0] lines_per_field_r;
  logic [HP_W-1:0] horizontal_period_r;
  logic [LINE_W-1:0] vertical_sync_delay_r;
  logic [PIXC_W-1:0] horizontal_sync_delay_r;
  logic [CLMP_W-1:0] horizontal_clamp_begin_r;
  logic [CLMP_W-1:0] horizontal_clamp_end_r;
  logic [LINE_W-1:0] vertical_clamp_begin_r;
  logic [LINE_W-1:0] vertical_clamp_end_r;
  logic [dsync_pkg::PIX_W-1:0] pixel_frequency_setting_r;

  logic master;
  logic sandcastle;
  assign master = sync_control_r[dsync_pkg::CTL_MASTER];
  assign sandcastle = sync_control_r[dsync_pkg::CTL_SANDCASTLE];

  // Clamp position in 480 ns units to clock cycles
  function automatic logic [HCYC_W-1:0] clamp_cyc(
      input logic [CLMP_W-1:0] v);
    clamp_cyc = HCYC_W'(v * dsync_pkg::CLAMP_STEP_CYC);
  endfunction : clamp_cyc

  // Window test shared by all region decoders
  function automatic logic in_win(input logic [HCYC_W-1:0] pos,
      input logic [HCYC_W-1:0] lo, input logic [HCYC_W-1:0] hi);
    in_win = (pos >= lo) && (pos < hi);
  endfunction : in_win

  // Software writes; fields wider than a byte split into low and high bytes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_control_r <= dsync_pkg::CTRL_RST;
      mask_r <= 2'h0;
      lines_per_field_r <= dsync_pkg::LPF_RST;
      horizontal_period_r <= dsync_pkg::HP_RST;
      vertical_sync_delay_r <= dsync_pkg::VDLY_RST;
      horizontal_sync_delay_r <= dsync_pkg::HDLY_RST;
      horizontal_clamp_begin_r <= dsync_pkg::HCB_RST;
      horizontal_clamp_end_r <= dsync_pkg::HCE_RST;
      vertical_clamp_begin_r <= dsync_pkg::VCB_RST;
      vertical_clamp_end_r <= dsync_pkg::VCE_RST;
      pixel_frequency_setting_r <= dsync_pkg::PIX_RST;
    end else if (wr_in) begin
      case (addr_in)
        dsync_pkg::OFS_CTRL: sync_control_r <= wdata_in[1:0];
        dsync_pkg::OFS_MASK: mask_r <= wdata_in[1:0];
        dsync_pkg::OFS_LPF_LO: lines_per_field_r[7:0] <= wdata_in;
        dsync_pkg::OFS_LPF_HI: lines_per_field_r[10:8] <= wdata_in[2:0];
        dsync_pkg::OFS_HP_LO: horizontal_period_r[7:0] <= wdata_in;
        dsync_pkg::OFS_HP_HI: horizontal_period_r[11:8] <= wdata_in[3:0];
        dsync_pkg::OFS_VDLY_LO: vertical_sync_delay_r[7:0] <= wdata_in;
        dsync_pkg::OFS_VDLY_HI: vertical_sync_delay_r[10:8] <= wdata_in[2:0];
        dsync_pkg::OFS_HDLY_LO: horizontal_sync_delay_r[7:0] <= wdata_in;
        dsync_pkg::OFS_HDLY_HI:
          horizontal_sync_delay_r[11:8] <= wdata_in[3:0];
        dsync_pkg::OFS_HCB: horizontal_clamp_begin_r <= wdata_in;
        dsync_pkg::OFS_HCE: horizontal_clamp_end_r <= wdata_in;
        dsync_pkg::OFS_VCB_LO: vertical_clamp_begin_r[7:0] <= wdata_in;
        dsync_pkg::OFS_VCB_HI: vertical_clamp_begin_r[10:8] <= wdata_in[2:0];
        dsync_pkg::OFS_VCE_LO: vertical_clamp_end_r[7:0] <= wdata_in;
        dsync_pkg::OFS_VCE_HI: vertical_clamp_end_r[10:8] <= wdata_in[2:0];
        dsync_pkg::OFS_PIX_LO: pixel_frequency_setting_r[7:0] <= wdata_in;
        dsync_pkg::OFS_PIX_HI:
          pixel_frequency_setting_r[9:8] <= wdata_in[1:0];
        default: ;
      endcase
    end
  end

  // Pixel enable; not line locked, so sync logic never relies on it
  dsync_pixclk u_pixclk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .step_in(pixel_frequency_setting_r),
    .pix_en_out(pix_en_out)
  );

  // Sync pins pass two flops, third stage is for edge detection only
  logic hs_m_r, hs_s_r, hs_d_r;
  logic vs_m_r, vs_s_r, vs_d_r;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hs_m_r <= 1'b0;
      hs_s_r <= 1'b0;
      hs_d_r <= 1'b0;
      vs_m_r <= 1'b0;
      vs_s_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      hs_m_r <= hsync_in;
      hs_s_r <= hs_m_r;
      hs_d_r <= hs_s_r;
      vs_m_r <= vsync_in;
      vs_s_r <= vs_m_r;
      vs_d_r <= vs_s_r;
    end
  end

  logic hs_rise, vs_rise;
  assign hs_rise = hs_s_r && !hs_d_r;
  assign vs_rise = vs_s_r && !vs_d_r;

  // Sandcastle on the H pin: each rise is H; a long pulse also carries V
  dsync_sc_e sc_state_r;
  logic [HCYC_W-1:0] sc_cnt_r;
  logic sc_v_evt;
  assign sc_v_evt = (sc_state_r == DSYNC_SC_HIGH) && hs_s_r &&
                    (sc_cnt_r == HCYC_W'(dsync_pkg::SC_VS_CYC - 1));

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sc_state_r <= DSYNC_SC_IDLE;
      sc_cnt_r <= '0;
    end else begin
      case (sc_state_r)
        DSYNC_SC_IDLE: begin
          sc_cnt_r <= '0;
          if (hs_rise) begin
            sc_state_r <= DSYNC_SC_HIGH;
          end
        end
        DSYNC_SC_HIGH: begin
          sc_cnt_r <= sc_cnt_r + 1'b1;
          if (!hs_s_r) begin
            sc_state_r <= DSYNC_SC_IDLE;
          end else if (sc_v_evt) begin
            sc_state_r <= DSYNC_SC_VERT;
          end
        end
        DSYNC_SC_VERT: begin
          if (!hs_s_r) begin
            sc_state_r <= DSYNC_SC_IDLE;
          end
        end
        default: sc_state_r <= DSYNC_SC_IDLE;
      endcase
    end
  end

  // Position counters
  logic [HCYC_W-1:0] hcyc_r;
  logic [PIXC_W-1:0] pixc_r;
  logic [LINE_W-1:0] line_r;
  logic h_wrap, m_v_evt, h_evt, v_evt;

  // Master line end, period in 30 ns units; a count already past the end
  // (run on in slave mode, or a shortened period) wraps at once
  assign h_wrap = hcyc_r >=
      HCYC_W'(horizontal_period_r * dsync_pkg::HP_STEP_CYC - 1);
  assign m_v_evt = h_wrap && (line_r >= lines_per_field_r - 1'b1);
  // Slave events come from pins in either form, at whatever rate
  assign h_evt = master ? h_wrap : hs_rise;
  assign v_evt = master ? m_v_evt : (sandcastle ? sc_v_evt : vs_rise);

  // Restart on every accepted or generated sync; saturate otherwise
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hcyc_r <= '0;
      line_r <= '0;
    end else begin
      if (h_evt) begin
        hcyc_r <= '0;
      end else if (hcyc_r != '1) begin
        hcyc_r <= hcyc_r + 1'b1;
      end
      if (v_evt) begin
        line_r <= '0;
      end else if (h_evt && line_r != '1) begin
        line_r <= line_r + 1'b1;
      end
    end
  end

  // Pixel position counts pixel enables since the line start
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pixc_r <= '0;
    end else if (h_evt) begin
      pixc_r <= '0;
    end else if (pix_en_out && pixc_r != '1) begin
      pixc_r <= pixc_r + 1'b1;
    end
  end

  // Sync pins driven only in master mode
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      hsync_oe_out <= 1'b0;
      vsync_oe_out <= 1'b0;
    end else begin
      hsync_oe_out <= master;
      vsync_oe_out <= master;
      hsync_out <= master && (hcyc_r < HCYC_W'(dsync_pkg::HS_WIDTH_CYC));
      vsync_out <= master && (line_r < LINE_W'(dsync_pkg::VS_LINES));
    end
  end

  // Region decode against the counters
  logic v_clamp, h_clamp, clamp, v_char, h_char, char_area;
  assign v_clamp = in_win(HCYC_W'(line_r), HCYC_W'(vertical_clamp_begin_r),
      HCYC_W'(vertical_clamp_end_r));
  assign h_clamp = in_win(hcyc_r, clamp_cyc(horizontal_clamp_begin_r),
      clamp_cyc(horizontal_clamp_end_r));
  assign clamp = v_clamp || h_clamp;
  // Size from the generator's format; hold delay over 2 us
  assign v_char = in_win(HCYC_W'(line_r), HCYC_W'(vertical_sync_delay_r),
      HCYC_W'(vertical_sync_delay_r) + HCYC_W'(fmt_height_in));
  assign h_char = in_win(HCYC_W'(pixc_r), HCYC_W'(horizontal_sync_delay_r),
      HCYC_W'(horizontal_sync_delay_r) + HCYC_W'(fmt_width_in));
  assign char_area = v_char && h_char;

  // Pixel mux: clamp first, then character area, else border vector
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pix_out <= '0;
      char_area_out <= 1'b0;
      clamp_out <= 1'b0;
    end else begin
      clamp_out <= clamp;
      char_area_out <= char_area && !clamp;
      if (clamp) begin
        pix_out.rgb <= 3'h0;
        pix_out.blank <= sub0_pix_in.blank;
        pix_out.contrast <= sub0_pix_in.contrast;
      end else if (char_area) begin
        pix_out <= char_pix_in;
      end else begin
        pix_out <= border_pix_in;
      end
    end
  end

  // Sticky flags at raw pin edges; a read clears, but a new edge wins
  logic stat_rd;
  logic [1:0] stat_set;
  assign stat_rd = rd_in && (addr_in == dsync_pkg::OFS_STAT);
  assign stat_set = {master ? m_v_evt :
                     (sandcastle ? sc_v_evt : vs_rise),
                     master ? h_wrap : hs_rise};
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= (stat_rd ? 2'h0 : stat_r) | stat_set;
    end
  end

  // Level interrupt while any unmasked flag stands
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_r & mask_r);
    end
  end

  // Read data the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        dsync_pkg::OFS_CTRL: rdata_out <= {6'h00, sync_control_r};
        dsync_pkg::OFS_STAT: rdata_out <= {6'h00, stat_r};
        dsync_pkg::OFS_MASK: rdata_out <= {6'h00, mask_r};
        dsync_pkg::OFS_LPF_LO: rdata_out <= lines_per_field_r[7:0];
        dsync_pkg::OFS_LPF_HI: rdata_out <= {5'h00, lines_per_field_r[10:8]};
        dsync_pkg::OFS_HP_LO: rdata_out <= horizontal_period_r[7:0];
        dsync_pkg::OFS_HP_HI: rdata_out <= {4'h0, horizontal_period_r[11:8]};
        dsync_pkg::OFS_VDLY_LO: rdata_out <= vertical_sync_delay_r[7:0];
        dsync_pkg::OFS_VDLY_HI:
          rdata_out <= {5'h00, vertical_sync_delay_r[10:8]};
        dsync_pkg::OFS_HDLY_LO: rdata_out <= horizontal_sync_delay_r[7:0];
        dsync_pkg::OFS_HDLY_HI:
          rdata_out <= {4'h0, horizontal_sync_delay_r[11:8]};
        dsync_pkg::OFS_HCB: rdata_out <= horizontal_clamp_begin_r;
        dsync_pkg::OFS_HCE: rdata_out <= horizontal_clamp_end_r;
        dsync_pkg::OFS_VCB_LO: rdata_out <= vertical_clamp_begin_r[7:0];
        dsync_pkg::OFS_VCB_HI:
          rdata_out <= {5'h00, vertical_clamp_begin_r[10:8]};
        dsync_pkg::OFS_VCE_LO: rdata_out <= vertical_clamp_end_r[7:0];
        dsync_pkg::OFS_VCE_HI:
          rdata_out <= {5'h00, vertical_clamp_end_r[10:8]};
        dsync_pkg::OFS_PIX_LO: rdata_out <= pixel_frequency_setting_r[7:0];
        dsync_pkg::OFS_PIX_HI:
          rdata_out <= {6'h00, pixel_frequency_setting_r[9:8]};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule : dsync_timing

// ==== dsync_sync_src.sv ====
`timescale 1ns/1ps
// External sync source; pins idle low between pulses
module dsync_sync_src (
  input wire logic clock_in,
  output logic hsync_out,
  output logic vsync_out
);
  initial begin
    hsync_out = 1'b0;
    vsync_out = 1'b0;
  end
  // One pulse of len cycles on H (or combined pin) or V; spacing is free
  task automatic pulse(input logic v, input int len);
    @(posedge clock_in);
    if (v) vsync_out <= 1'b1;
    else hsync_out <= 1'b1;
    repeat (len) @(posedge clock_in);
    hsync_out <= 1'b0;
    vsync_out <= 1'b0;
  endtask : pulse
endmodule : dsync_sync_src

// ==== dsync_checker.sv ====
`timescale 1ns/1ps
// Port-level timing and bus checks on the sync block
module dsync_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic hsync_oe_out,
  input wire dsync_pkg::dsync_pix_s char_pix_in,
  input wire dsync_pkg::dsync_pix_s sub0_pix_in,
  input wire dsync_pkg::dsync_pix_s pix_out,
  input wire logic char_area_out,
  input wire logic clamp_out,
  input wire logic pix_en_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Clamp forces black, transparency from subtable zero
  clamp_black_a: assert property (clamp_out |->
    pix_out.rgb == 3'h0 && pix_out.blank == sub0_pix_in.blank &&
    pix_out.contrast == sub0_pix_in.contrast)
    else $error("clamp pixel not black");
  // Clamp wins over the character area
  char_no_clamp_a: assert property (char_area_out |-> !clamp_out)
    else $error("char area during clamp");
  char_pix_a: assert property (char_area_out |->
    pix_out == $past(char_pix_in))
    else $error("char pixel not passed");
  // Read data only in the cycle after a read
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside slot");
  unmapped_rd_a: assert property (rd_in && addr_in > 5'h12 |=>
    rdata_out == 8'h00)
    else $error("unmapped read not zero");
  // Slave mode never drives the sync pins
  slave_quiet_a: assert property (!hsync_oe_out |->
    !hsync_out && !vsync_out)
    else $error("sync driven in slave");
  // Pixel rate stays below half the clock, so enables never touch
  pix_pulse_a: assert property (pix_en_out |=> !pix_en_out)
    else $error("pixel enable too long");
  mask_off_a: assert property (wr_in && addr_in == dsync_pkg::OFS_MASK &&
    wdata_in[1:0] == 2'h0 |-> ##2 !irq_out) else $error("masked irq high");
endmodule : dsync_checker

bind dsync_timing dsync_checker u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
  .hsync_oe_out(hsync_oe_out), .char_pix_in(char_pix_in),
  .sub0_pix_in(sub0_pix_in), .pix_out(pix_out), .clamp_out(clamp_out),
  .char_area_out(char_area_out), .pix_en_out(pix_en_out), .irq_out(irq_out));

// ==== test_dsync_timing.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_dsync_timing;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic hs_pin, vs_pin, hsync_out, hsync_oe_out, vsync_out, vsync_oe_out;
  logic char_area_out, clamp_out, pix_en_out, irq_out;
  logic [7:0] rdata_out;
  dsync_pkg::dsync_pix_s pix_out;
  int miscompares = 0;
  int n_compared = 0;
  // Distinct colours so each region is told apart at the output
  always #5 clock_in = ~clock_in;
  dsync_sync_src src (.clock_in(clock_in), .hsync_out(hs_pin),
    .vsync_out(vs_pin));
  dsync_timing DUT (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .hsync_in(hs_pin), .vsync_in(vs_pin),
    .hsync_out(hsync_out), .hsync_oe_out(hsync_oe_out),
    .vsync_out(vsync_out), .vsync_oe_out(vsync_oe_out),
    .fmt_width_in(12'h008), .fmt_height_in(11'h002),
    .char_pix_in(5'h15), .border_pix_in(5'h0e), .sub0_pix_in(5'h03),
    .pix_out(pix_out), .char_area_out(char_area_out),
    .clamp_out(clamp_out), .pix_en_out(pix_en_out), .irq_out(irq_out));
  task automatic tally_and_finish;
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  // Read data are taken in the single cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] ex);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata_out)
  endtask : rd_chk
  // Counts edges until s reaches lvl; bounded so a stuck output fails
  task automatic cnt(ref logic s, input logic lvl, output int n);
    for (n = 0; n < 20000 && s !== lvl; n++) begin
      @(posedge clock_in);
      #1;
    end
    if (n == 20000) `CHK("wait", lvl, s)
  endtask : cnt
  task automatic t_defaults;
    logic [12:0] tbl [19] = '{13'h0000, 13'h0200, 13'h0371, 13'h0402,
      13'h0555, 13'h0608, 13'h0720, 13'h0800, 13'h0948, 13'h0a00, 13'h0b00,
      13'h0c0a, 13'h0d00, 13'h0e00, 13'h0f04, 13'h1000, 13'h11a4, 13'h1200,
      13'h1f00};
    foreach (tbl[i]) begin
      rd_chk(tbl[i][12:8], tbl[i][7:0]);
    end
  endtask : t_defaults
  task automatic t_slave;
    int n;
    wr(dsync_pkg::OFS_MASK, 8'h03);
    src.pulse(1'b0, 20);
    repeat (30) @(posedge clock_in);
    `CHK("irq", 1'b1, irq_out)
    rd_chk(dsync_pkg::OFS_STAT, 8'h01);
    rd_chk(dsync_pkg::OFS_STAT, 8'h00);
    #1 `CHK("irq", 1'b0, irq_out)
    src.pulse(1'b1, 20);
    cnt(irq_out, 1'b1, n);
    rd_chk(dsync_pkg::OFS_STAT, 8'h02);
    wr(dsync_pkg::OFS_MASK, 8'h00);
    src.pulse(1'b0, 20);
    repeat (10) @(posedge clock_in);
    `CHK("irq", 1'b0, irq_out)
    rd_chk(dsync_pkg::OFS_STAT, 8'h01);
    // Sandcastle: V pin ignored, long pulse on H carries both
    wr(dsync_pkg::OFS_CTRL, 8'h02);
    src.pulse(1'b1, 20);
    repeat (10) @(posedge clock_in);
    rd_chk(dsync_pkg::OFS_STAT, 8'h00);
    src.pulse(1'b0, 900);
    repeat (10) @(posedge clock_in);
    rd_chk(dsync_pkg::OFS_STAT, 8'h03);
    src.pulse(1'b0, 50);
    repeat (10) @(posedge clock_in);
    rd_chk(dsync_pkg::OFS_STAT, 8'h01);
  endtask : t_slave
  task automatic t_master;
    int n;
    int w;
    // Short line and field, short delays, narrow horizontal clamp
    wr(dsync_pkg::OFS_HP_LO, 8'hc8);
    wr(dsync_pkg::OFS_HP_HI, 8'h00);
    wr(dsync_pkg::OFS_LPF_LO, 8'h08);
    wr(dsync_pkg::OFS_LPF_HI, 8'h00);
    wr(dsync_pkg::OFS_VDLY_LO, 8'h04);
    // 32 pixels at the default pixel rate last well over 2 us
    wr(dsync_pkg::OFS_HDLY_LO, 8'h20);
    wr(dsync_pkg::OFS_HCE, 8'h02);
    rd_chk(dsync_pkg::OFS_LPF_LO, 8'h08);
    wr(dsync_pkg::OFS_CTRL, 8'h01);
    // The switch lands mid field; skip that cut pulse, wait for a field start
    repeat (2) @(posedge clock_in);
    cnt(vsync_out, 1'b0, n);
    cnt(vsync_out, 1'b1, n);
    `CHK("oe", 1'b1, hsync_oe_out)
    `CHK("voe", 1'b1, vsync_oe_out)
    cnt(hsync_out, 1'b0, w);
    `CHK("hwidth", dsync_pkg::HS_WIDTH_CYC, w)
    cnt(hsync_out, 1'b1, n);
    `CHK("hperiod", 200 * dsync_pkg::HP_STEP_CYC, n + w)
    repeat (20) @(posedge clock_in);
    `CHK("vclamp", 5'h03, pix_out)
    repeat (4) begin
      cnt(hsync_out, 1'b0, n);
      cnt(hsync_out, 1'b1, n);
    end
    repeat (20) @(posedge clock_in);
    `CHK("hclamp", 1'b1, clamp_out)
    repeat (130) @(posedge clock_in);
    `CHK("clamp end", 1'b0, clamp_out)
    `CHK("border", 5'h0e, pix_out)
    cnt(char_area_out, 1'b1, n);
    `CHK("char", 5'h15, pix_out)
    cnt(vsync_out, 1'b1, n);
    cnt(vsync_out, 1'b0, n);
    `CHK("vwidth", 3 * 200 * dsync_pkg::HP_STEP_CYC, n)
  endtask : t_master
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    t_defaults();
    t_slave();
    t_master();
    tally_and_finish();
  end
  // Whole run needs about 12k cycles; allow over four times as much
  initial begin
    #600000;
    miscompares++;
    tally_and_finish();
  end
endmodule : test_dsync_timing
